// ===== testbench/smrd_ctrl_model.sv
// Controller side of the command bus, clocked by the link clock
module smrd_ctrl_model (
  input wire logic ck,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [3:0] ba,
  output logic [11:0] addr
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus: deselected, command pins high
  initial begin
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    ba = 4'h0;
    addr = 12'h000;
  end

  // No training commands issued
  // Only register writes leave this model, so refresh is never overlapped.
  // Bank bits address register
  task automatic mode_register_write_command(input logic [3:0] sel, input logic [11:0] op);
    @(negedge ck);
    {cs_n, ras_n, cas_n, we_n} = 4'h0;
    ba = sel;
    addr = op;
    @(negedge ck);
    // Released bus shows the inverse, never a stale copy
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    ba = ~sel;
    addr = ~op;
  endtask : mode_register_write_command
endmodule : smrd_ctrl_model

// ===== testbench/test_sgram_mode_register_decode.sv
module test_sgram_mode_register_decode;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [3:0] sel;
    logic [11:0] op;
    logic ri;
    logic [31:0] exp;
  } smrd_row_t;

  logic mclk = 1'b0;
  logic ck = 1'b0;
  logic sys_rst = 1'b1;
  logic mirror_function = 1'b0;
  logic read_inversion = 1'b0;
  logic rd_crc_valid = 1'b0;
  logic [3:0] rd_crc_data = 4'h0;
  logic wr_crc_valid = 1'b0;
  logic [3:0] wr_crc_data = 4'h0;
  logic cs_n, ras_n, cas_n, we_n;
  logic [3:0] ba;
  logic [11:0] addr;
  logic [3:0] error_detect_pins, vref_offset_upper, vref_offset_lower;
  logic [2:0] checksum_write_latency;
  logic [1:0] checksum_read_latency, duty_cycle_corrector;
  logic clock_receiver_powerdown_bit, refresh_training_block_bit;
  logic alignment_point_select, vref_external, vref_merge;
  logic vref_internal_07, vref_internal_05, low_freq_mode;
  logic auto_clock_sync, preamble_enable, preamble_dbi_high;
  logic temp_sensor_enable, address_training_mode, register_write_enable;
  logic [31:0] obs;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  smrd_row_t rows [15];

  // All level outputs packed into one 32-bit word for one compare per row
  assign obs = {register_write_enable, checksum_write_latency,
    checksum_read_latency, clock_receiver_powerdown_bit,
    refresh_training_block_bit, alignment_point_select, vref_external,
    vref_merge, vref_internal_07, vref_internal_05, address_training_mode,
    duty_cycle_corrector, vref_offset_upper, vref_offset_lower,
    low_freq_mode, auto_clock_sync, preamble_enable, preamble_dbi_high,
    temp_sensor_enable, 3'b000};

  always #50 mclk = ~mclk;

  // Link clock offset so its edges never line up with the core clock
  initial begin
    #7;
    forever #24 ck = ~ck;
  end

  smrd_top u_dut (.mclk, .sys_rst, .ck, .cs_n, .ras_n, .cas_n, .we_n, .ba,
    .addr, .mirror_function, .read_inversion, .rd_crc_valid, .rd_crc_data,
    .wr_crc_valid, .wr_crc_data, .error_detect_pins, .checksum_write_latency,
    .checksum_read_latency, .clock_receiver_powerdown_bit,
    .refresh_training_block_bit, .alignment_point_select, .vref_external,
    .vref_merge, .vref_internal_07, .vref_internal_05, .vref_offset_upper,
    .vref_offset_lower, .low_freq_mode, .auto_clock_sync, .preamble_enable,
    .preamble_dbi_high, .temp_sensor_enable, .duty_cycle_corrector,
    .address_training_mode, .register_write_enable);

  smrd_ctrl_model u_ctrl (.ck, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr);

  task automatic check_obs(input string what, input logic [31:0] exp);
    num_checks++;
    if (obs !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, obs);
    end
  endtask : check_obs

  task automatic check_pins(input string what, input logic [3:0] exp);
    num_checks++;
    if (error_detect_pins !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, error_detect_pins);
    end
  endtask : check_pins

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  // Ten core cycles cover the crossing and the acknowledge
  task automatic mrs_wait(input logic [3:0] sel, input logic [11:0] op);
    u_ctrl.mode_register_write_command(sel, op);
    repeat (10) @(negedge mclk);
  endtask : mrs_wait

  // One nibble in, pins watched until just past its slot
  task automatic crc_probe(input logic is_rd, input logic [3:0] d,
      input int lat, input logic [3:0] hold, input logic shown);
    @(negedge mclk);
    rd_crc_valid = is_rd;
    wr_crc_valid = !is_rd;
    rd_crc_data = d;
    wr_crc_data = d;
    for (int i = 1; i <= lat + 2; i++) begin
      @(negedge mclk);
      rd_crc_valid = 1'b0;
      wr_crc_valid = 1'b0;
      check_pins("crc_pins", (shown && i == lat) ? d : hold);
    end
  endtask : crc_probe

  // Cut a hang short
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fails++;
      print_verdict();
    end
  end

  initial begin
    rows = '{
      '{4'h4, 12'h755, 1'b0, 32'hd840_0000},
      '{4'h5, 12'h006, 1'b0, 32'hdb40_0000},
      '{4'h5, 12'h002, 1'b0, 32'hda40_0000},
      '{4'h6, 12'h001, 1'b0, 32'hdac0_0000},
      '{4'h6, 12'h00b, 1'b0, 32'hdaa0_0000},
      '{4'h6, 12'h5a8, 1'b0, 32'hda10_5a00},
      '{4'h6, 12'hff8, 1'b0, 32'hda10_0000},
      '{4'h7, 12'hcf8, 1'b0, 32'hda0b_00f8},
      '{4'he, 12'hfff, 1'b1, 32'hda0b_00e8},
      '{4'h6, 12'h004, 1'b0, 32'hda43_00f8},
      '{4'hf, 12'h4ff, 1'b0, 32'h5a47_00f8},
      '{4'h7, 12'h000, 1'b0, 32'h5a47_00f8},
      '{4'h5, 12'h000, 1'b0, 32'h5a47_00f8},
      '{4'hf, 12'h300, 1'b0, 32'hda43_00f8},
      '{4'h7, 12'h000, 1'b0, 32'hda40_0000}};
    repeat (5) @(negedge mclk);
    check_obs("reset_fields", 32'h8040_0000);
    check_pins("reset_hold", 4'hf);
    sys_rst = 1'b0;
    repeat (4) @(negedge mclk);
    $display("reset test done");
    for (int i = 0; i < 15; i++) begin
      read_inversion = rows[i].ri;
      mrs_wait(rows[i].sel, rows[i].op);
      check_obs($sformatf("row%0d", i), rows[i].exp);
    end
    $display("register table test done");
    // Strap picks the other enable bit
    mirror_function = 1'b1;
    repeat (4) @(negedge mclk);
    mrs_wait(4'hf, 12'h100);
    check_obs("strap_one", 32'h5a40_0000);
    mrs_wait(4'h5, 12'h004);
    check_obs("strap_block", 32'h5a40_0000);
    mirror_function = 1'b0;
    repeat (4) @(negedge mclk);
    check_obs("strap_zero", 32'hda40_0000);
    mrs_wait(4'hf, 12'h300);
    $display("mirror test done");
    // Slot is read field plus 2, write field plus 10
    crc_probe(1'b1, 4'ha, 4, 4'h5, 1'b1);
    crc_probe(1'b0, 4'hc, 15, 4'h5, 1'b1);
    mrs_wait(4'h4, 12'h153);
    crc_probe(1'b1, 4'ha, 4, 4'h3, 1'b0);
    crc_probe(1'b0, 4'hc, 15, 4'h3, 1'b0);
    $display("checksum test done");
    // Second reset in mid-run restores defaults
    sys_rst = 1'b1;
    repeat (5) @(negedge mclk);
    check_obs("rerun_fields", 32'h8040_0000);
    check_pins("rerun_hold", 4'hf);
    sys_rst = 1'b0;
    repeat (4) @(negedge mclk);
    // Link must accept commands again after the mid-run reset
    mrs_wait(4'h5, 12'h002);
    check_obs("rerun_write", 32'h8240_0000);
    $display("second reset test done");
    print_verdict();
  end
endmodule : test_sgram_mode_register_decode

// ===== verilog/smrd_pkg.sv
package smrd_pkg;
  // Register select codes, bank bits as {ba3, ba2, ba1, ba0}
  localparam logic [3:0] SEL_EDC_CFG = 4'h4;
  localparam logic [3:0] SEL_LOW_POWER_PLL = 4'h5;
  localparam logic [3:0] SEL_ALIGN_VREF = 4'h6;
  localparam logic [3:0] SEL_MISC_FEATURE = 4'h7;
  localparam logic [3:0] SEL_TRAIN_WRITE_EN = 4'hf;
  localparam int OPCODE_W = 12;

  // Error-detection config field positions
  localparam int EDC_HOLD_LSB = 0;
  localparam int EDC_WL_LSB = 4;
  localparam int EDC_RL_LSB = 7;
  localparam int EDC_RD_CRC_BIT = 9;
  localparam int EDC_WR_CRC_BIT = 10;
  // Low power / PLL fields
  localparam int LP_CLK_RX_OFF_BIT = 1;
  localparam int LP_REF_TRAIN_BLK_BIT = 2;
  // Alignment / Vref fields
  localparam int AV_ALIGN_PIN_BIT = 0;
  localparam int AV_MERGE_BIT = 1;
  localparam int AV_AUTO_TRAIN_BIT = 2;
  localparam int AV_INTERNAL_BIT = 3;
  localparam int AV_OFS_LOW_LSB = 4;
  localparam int AV_OFS_HIGH_LSB = 8;
  localparam logic [3:0] VREF_OFS_AUTO = 4'hf;
  // Misc feature fields
  localparam int MF_LOW_FREQ_BIT = 3;
  localparam int MF_AUTO_SYNC_BIT = 4;
  localparam int MF_PREAMBLE_BIT = 5;
  localparam int MF_TEMP_SENSE_BIT = 6;
  localparam int MF_HALF_VREF_BIT = 7;
  localparam int MF_DCC_LSB = 10;
  // Training / write-enable fields
  localparam int TW_ENABLE_MF0_BIT = 8;
  localparam int TW_ENABLE_MF1_BIT = 9;
  localparam int TW_ADDR_TRAIN_BIT = 10;
  localparam logic [11:0] TW_USED_MASK = 12'hf00;

  // Reset values
  localparam logic [11:0] EDC_CFG_RST = 12'h000f;
  localparam logic [11:0] LOW_POWER_PLL_RST = 12'h0000;
  localparam logic [11:0] ALIGN_VREF_RST = 12'h0000;
  localparam logic [11:0] MISC_FEATURE_RST = 12'h0000;
  localparam logic [11:0] TRAIN_WRITE_EN_RST = 12'h0300;

  // CRC latency mapping
  localparam int CRC_WL_BASE = 8;
  localparam int CRC_RL_BASE = 0;
endpackage : smrd_pkg

// ===== verilog/smrd_sync.sv
module smrd_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage1_next;
  logic [WIDTH-1:0] stage2_next;

  // First stage feeds only the second
  always_comb begin
    stage1_next = rst ? RST_VAL : d;
    stage2_next = rst ? RST_VAL : stage1_reg;
  end

  always_ff @(posedge clk) begin
    stage1_reg <= stage1_next;
    stage2_reg <= stage2_next;
  end

  assign q = stage2_reg;
endmodule : smrd_sync

// ===== verilog/smrd_top.sv
module smrd_top #(
  parameter int PIPE_DEPTH = 16
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ck,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [3:0] ba,
  input wire logic [11:0] addr,
  input wire logic mirror_function,
  input wire logic read_inversion,
  input wire logic rd_crc_valid,
  input wire logic [3:0] rd_crc_data,
  input wire logic wr_crc_valid,
  input wire logic [3:0] wr_crc_data,
  output logic [3:0] error_detect_pins,
  output logic [2:0] checksum_write_latency,
  output logic [1:0] checksum_read_latency,
  output logic clock_receiver_powerdown_bit,
  output logic refresh_training_block_bit,
  output logic alignment_point_select,
  output logic vref_external,
  output logic vref_merge,
  output logic vref_internal_07,
  output logic vref_internal_05,
  output logic [3:0] vref_offset_upper,
  output logic [3:0] vref_offset_lower,
  output logic low_freq_mode,
  output logic auto_clock_sync,
  output logic preamble_enable,
  output logic preamble_dbi_high,
  output logic temp_sensor_enable,
  output logic [1:0] duty_cycle_corrector,
  output logic address_training_mode,
  output logic register_write_enable
);
  // Longest write latency tap must exist in the delay line
  if (PIPE_DEPTH < smrd_pkg::CRC_WL_BASE + 8) begin : g_depth_chk
    $error("PIPE_DEPTH too small for the longest CRC latency");
  end

  // Link side, on ck
  logic ck_rst;
  logic ack_sync;
  logic req_tgl_reg;
  logic req_tgl_next;
  logic [15:0] cmd_word_reg;
  logic [15:0] cmd_word_next;
  logic mrs_hit;
  logic link_busy;

  // Reset brought into the link domain
  smrd_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_ck_rst_sync (
    .clk(ck),
    .rst(1'b0),
    .d(sys_rst),
    .q(ck_rst)
  );

  // Command pins are synchronous to ck, so decoded directly
  assign mrs_hit = ~cs_n & ~ras_n & ~cas_n & ~we_n;
  assign link_busy = req_tgl_reg != ack_sync;

  always_comb begin
    cmd_word_next = cmd_word_reg;
    req_tgl_next = req_tgl_reg;
    if (ck_rst) begin
      cmd_word_next = 16'h0000;
      req_tgl_next = 1'b0;
    end else if (mrs_hit && !link_busy) begin
      // Word held still until the core acknowledges it
      cmd_word_next = {ba, addr};
      req_tgl_next = ~req_tgl_reg;
    end
  end

  always_ff @(posedge ck) begin
    cmd_word_reg <= cmd_word_next;
    req_tgl_reg <= req_tgl_next;
  end

  // Core side, on mclk; the ack synchronizer runs on ck
  logic req_sync;
  logic mf_sync;
  logic ack_tgl_reg;
  logic ack_tgl_next;
  logic new_cmd;
  logic [3:0] cmd_sel;
  logic [11:0] cmd_op;
  logic write_allowed;
  logic [11:0] edc_cfg_reg;
  logic [11:0] edc_cfg_next;
  logic [11:0] lp_pll_reg;
  logic [11:0] lp_pll_next;
  logic [11:0] align_vref_reg;
  logic [11:0] align_vref_next;
  logic [11:0] misc_feat_reg;
  logic [11:0] misc_feat_next;
  logic [11:0] train_we_reg;
  logic [11:0] train_we_next;

  smrd_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_req_sync (
    .clk(mclk),
    .rst(sys_rst),
    .d(req_tgl_reg),
    .q(req_sync)
  );

  smrd_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_ack_sync (
    .clk(ck),
    .rst(ck_rst),
    .d(ack_tgl_reg),
    .q(ack_sync)
  );

  // Strap pin, asynchronous to mclk
  smrd_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_mf_sync (
    .clk(mclk),
    .rst(sys_rst),
    .d(mirror_function),
    .q(mf_sync)
  );

  assign new_cmd = req_sync != ack_tgl_reg;
  assign cmd_sel = cmd_word_reg[15:12];
  assign cmd_op = cmd_word_reg[11:0];
  // enable bit picked by mirror strap
  assign write_allowed = mf_sync ?
    train_we_reg[smrd_pkg::TW_ENABLE_MF1_BIT] :
    train_we_reg[smrd_pkg::TW_ENABLE_MF0_BIT];

  // registers only change on reset or an accepted write
  always_comb begin
    edc_cfg_next = edc_cfg_reg;
    lp_pll_next = lp_pll_reg;
    align_vref_next = align_vref_reg;
    misc_feat_next = misc_feat_reg;
    train_we_next = train_we_reg;
    ack_tgl_next = ack_tgl_reg;
    if (sys_rst) begin
      edc_cfg_next = smrd_pkg::EDC_CFG_RST;
      lp_pll_next = smrd_pkg::LOW_POWER_PLL_RST;
      align_vref_next = smrd_pkg::ALIGN_VREF_RST;
      misc_feat_next = smrd_pkg::MISC_FEATURE_RST;
      train_we_next = smrd_pkg::TRAIN_WRITE_EN_RST;
      ack_tgl_next = 1'b0;
    end else if (new_cmd) begin
      ack_tgl_next = req_sync;
      if (cmd_sel == smrd_pkg::SEL_TRAIN_WRITE_EN) begin
        train_we_next = cmd_op & smrd_pkg::TW_USED_MASK;
      end else if (write_allowed) begin
        unique case (cmd_sel)
          smrd_pkg::SEL_EDC_CFG: edc_cfg_next = cmd_op;
          smrd_pkg::SEL_LOW_POWER_PLL: lp_pll_next = cmd_op;
          smrd_pkg::SEL_ALIGN_VREF: begin
            align_vref_next = cmd_op;
            align_vref_next[smrd_pkg::AV_AUTO_TRAIN_BIT] = 1'b0;
          end
          smrd_pkg::SEL_MISC_FEATURE: misc_feat_next = cmd_op;
          default: ; // Other registers live outside this block
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    edc_cfg_reg <= edc_cfg_next;
    lp_pll_reg <= lp_pll_next;
    align_vref_reg <= align_vref_next;
    misc_feat_reg <= misc_feat_next;
    train_we_reg <= train_we_next;
    ack_tgl_reg <= ack_tgl_next;
  end

  // CRC latency pipes
  logic [4:0] rd_pipe_reg [PIPE_DEPTH];
  logic [4:0] rd_pipe_next [PIPE_DEPTH];
  logic [4:0] wr_pipe_reg [PIPE_DEPTH];
  logic [4:0] wr_pipe_next [PIPE_DEPTH];
  logic [4:0] rd_tap;
  logic [4:0] wr_tap;
  logic [3:0] edc_reg;
  logic [3:0] edc_next;
  int rd_idx;
  int wr_idx;

  assign rd_idx = smrd_pkg::CRC_RL_BASE +
    int'(edc_cfg_reg[smrd_pkg::EDC_RL_LSB +: 2]);
  assign wr_idx = smrd_pkg::CRC_WL_BASE +
    int'(edc_cfg_reg[smrd_pkg::EDC_WL_LSB +: 3]);
  assign rd_tap = rd_pipe_reg[rd_idx];
  assign wr_tap = wr_pipe_reg[wr_idx];

  // Plain shift lines; a tap picks the latency
  always_comb begin
    rd_pipe_next[0] = sys_rst ? 5'h00 : {rd_crc_valid, rd_crc_data};
    wr_pipe_next[0] = sys_rst ? 5'h00 : {wr_crc_valid, wr_crc_data};
    for (int i = 1; i < PIPE_DEPTH; i++) begin
      rd_pipe_next[i] = sys_rst ? 5'h00 : rd_pipe_reg[i-1];
      wr_pipe_next[i] = sys_rst ? 5'h00 : wr_pipe_reg[i-1];
    end
  end

  always_ff @(posedge mclk) begin
    rd_pipe_reg <= rd_pipe_next;
    wr_pipe_reg <= wr_pipe_next;
  end

  // Read CRC wins a collision; bursts cannot overlap legally
  always_comb begin
    // idle nibble is the hold pattern
    edc_next = edc_cfg_reg[smrd_pkg::EDC_HOLD_LSB +: 4];
    if (sys_rst) begin
      edc_next = smrd_pkg::EDC_CFG_RST[3:0];
    end else if (rd_tap[4] && edc_cfg_reg[smrd_pkg::EDC_RD_CRC_BIT]) begin
      edc_next = rd_tap[3:0];
    end else if (wr_tap[4] && edc_cfg_reg[smrd_pkg::EDC_WR_CRC_BIT]) begin
      edc_next = wr_tap[3:0];
    end
  end

  always_ff @(posedge mclk) begin
    edc_reg <= edc_next;
  end

  // Field outputs
  logic vref_auto;

  assign error_detect_pins = edc_reg;
  assign checksum_write_latency = edc_cfg_reg[smrd_pkg::EDC_WL_LSB +: 3];
  assign checksum_read_latency = edc_cfg_reg[smrd_pkg::EDC_RL_LSB +: 2];
  assign clock_receiver_powerdown_bit =
    lp_pll_reg[smrd_pkg::LP_CLK_RX_OFF_BIT];
  // flag exported to the command checker
  assign refresh_training_block_bit =
    lp_pll_reg[smrd_pkg::LP_REF_TRAIN_BLK_BIT];
  assign alignment_point_select =
    align_vref_reg[smrd_pkg::AV_ALIGN_PIN_BIT];

  assign vref_merge = align_vref_reg[smrd_pkg::AV_MERGE_BIT];
  // half bit picks 0.5 or 0.7
  assign vref_external = ~vref_merge &
    ~align_vref_reg[smrd_pkg::AV_INTERNAL_BIT];
  assign vref_internal_07 = ~vref_merge &
    align_vref_reg[smrd_pkg::AV_INTERNAL_BIT] &
    ~misc_feat_reg[smrd_pkg::MF_HALF_VREF_BIT];
  assign vref_internal_05 = ~vref_merge &
    align_vref_reg[smrd_pkg::AV_INTERNAL_BIT] &
    misc_feat_reg[smrd_pkg::MF_HALF_VREF_BIT];

  assign vref_auto = align_vref_reg[smrd_pkg::AV_OFS_LOW_LSB +: 4] ==
    smrd_pkg::VREF_OFS_AUTO;
  assign vref_offset_lower = vref_auto ? 4'h0 :
    align_vref_reg[smrd_pkg::AV_OFS_LOW_LSB +: 4];
  assign vref_offset_upper = vref_auto ? 4'h0 :
    align_vref_reg[smrd_pkg::AV_OFS_HIGH_LSB +: 4];

  assign low_freq_mode = misc_feat_reg[smrd_pkg::MF_LOW_FREQ_BIT];
  assign auto_clock_sync = misc_feat_reg[smrd_pkg::MF_AUTO_SYNC_BIT];
  assign preamble_enable = misc_feat_reg[smrd_pkg::MF_PREAMBLE_BIT];
  // inversion pins held high without inversion
  assign preamble_dbi_high = preamble_enable & ~read_inversion;
  assign temp_sensor_enable = misc_feat_reg[smrd_pkg::MF_TEMP_SENSE_BIT];
  assign duty_cycle_corrector = misc_feat_reg[smrd_pkg::MF_DCC_LSB +: 2];
  assign address_training_mode = train_we_reg[smrd_pkg::TW_ADDR_TRAIN_BIT];
  assign register_write_enable = write_allowed;

  // Checks; only the capture pair runs on the link clock
  read_crc_out_a: assert property (@(posedge mclk)
    disable iff (sys_rst) rd_tap[4] && edc_cfg_reg[smrd_pkg::EDC_RD_CRC_BIT]
    |=> error_detect_pins == $past(rd_tap[3:0]))
    else $error("read CRC not on error pins");
  write_crc_out_a: assert property (@(posedge mclk)
    disable iff (sys_rst) wr_tap[4] && edc_cfg_reg[smrd_pkg::EDC_WR_CRC_BIT] &&
    !(rd_tap[4] && edc_cfg_reg[smrd_pkg::EDC_RD_CRC_BIT])
    |=> error_detect_pins == $past(wr_tap[3:0]))
    else $error("write CRC not on error pins");
  hold_pattern_a: assert property (@(posedge mclk)
    disable iff (sys_rst) !(rd_tap[4] && edc_cfg_reg[smrd_pkg::EDC_RD_CRC_BIT])
    && !(wr_tap[4] && edc_cfg_reg[smrd_pkg::EDC_WR_CRC_BIT])
    |=> error_detect_pins == $past(edc_cfg_reg[3:0]))
    else $error("hold pattern missing");
  write_block_a: assert property (@(posedge mclk)
    disable iff (sys_rst) new_cmd && !write_allowed &&
    cmd_sel != smrd_pkg::SEL_TRAIN_WRITE_EN
    |=> $stable(align_vref_reg) && $stable(misc_feat_reg) &&
        $stable(lp_pll_reg) && $stable(edc_cfg_reg))
    else $error("blocked write changed a register");
  train_write_a: assert property (@(posedge mclk)
    disable iff (sys_rst) new_cmd && cmd_sel == smrd_pkg::SEL_TRAIN_WRITE_EN
    |=> train_we_reg == {$past(cmd_op[11:8]), 8'h00})
    else $error("training register write lost");
  align_write_a: assert property (@(posedge mclk)
    disable iff (sys_rst) new_cmd && write_allowed &&
    cmd_sel == smrd_pkg::SEL_ALIGN_VREF
    |=> align_vref_reg == ($past(cmd_op) & 12'hffb))
    else $error("alignment register write wrong");
  vref_source_a: assert property (@(posedge mclk)
    disable iff (sys_rst) align_vref_reg[3:1] == 3'h0 && !misc_feat_reg[7]
    |-> vref_external && !vref_internal_07 && !vref_internal_05)
    else $error("external reference not selected");
  train_start_a: assert property (@(posedge mclk)
    disable iff (sys_rst) new_cmd && cmd_sel == smrd_pkg::SEL_ALIGN_VREF
    |=> !align_vref_reg[smrd_pkg::AV_AUTO_TRAIN_BIT])
    else $error("unsupported training bit set");
  handshake_a: assert property (@(posedge ck) disable iff (ck_rst)
    mrs_hit && !link_busy
    |=> cmd_word_reg == $past({ba, addr}) && req_tgl_reg != $past(req_tgl_reg))
    else $error("command not captured");
  word_stable_a: assert property (@(posedge ck) disable iff (ck_rst)
    link_busy |=> $stable(cmd_word_reg) || !$past(link_busy))
    else $error("word changed while in flight");

  cover_train_c: cover property (@(posedge mclk) disable iff (sys_rst)
    new_cmd && cmd_sel == smrd_pkg::SEL_TRAIN_WRITE_EN);
  cover_blocked_c: cover property (@(posedge mclk) disable iff (sys_rst)
    new_cmd && !write_allowed && cmd_sel == smrd_pkg::SEL_MISC_FEATURE);
  cover_rd_crc_c: cover property (@(posedge mclk) disable iff (sys_rst)
    rd_tap[4] && edc_cfg_reg[smrd_pkg::EDC_RD_CRC_BIT]);
endmodule : smrd_top
